// ### dv/tkr_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host processor on the bytewide bus
// ----------------------------------------
module tkr_host
  import tkr_pkg::*;
(
  input wire logic clk,
  output logic [12:0] addr,
  output logic chip_select_n,
  output logic second_chip_select_high,
  output logic output_enable_n,
  output logic write_enable_n,
  output tkr_byte_t data_in,
  input wire tkr_byte_t data_out
);
  // Idle bus, device deselected
  initial
  begin
    addr = 13'h0000;
    chip_select_n = 1'b1;
    second_chip_select_high = 1'b0;
    output_enable_n = 1'b1;
    write_enable_n = 1'b1;
    data_in = 8'h00;
  end

  // strobe-select write
  // Data is inverted after release so a stale byte never looks valid
  task automatic wr(input logic [12:0] a, input tkr_byte_t d);
    @(posedge clk);
    addr <= a;
    data_in <= d;
    chip_select_n <= 1'b0;
    second_chip_select_high <= 1'b1;
    output_enable_n <= 1'b1;
    write_enable_n <= 1'b0;
    @(posedge clk);
    write_enable_n <= 1'b1;
    chip_select_n <= 1'b1;
    data_in <= ~d;
  endtask : wr

  task automatic rd(input logic [12:0] a, output tkr_byte_t d);
    @(posedge clk);
    addr <= a;
    chip_select_n <= 1'b0;
    second_chip_select_high <= 1'b1;
    output_enable_n <= 1'b0;
    write_enable_n <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    d = data_out;
  endtask : rd

  // write with outputs enabled, second select as given
  task automatic odd_wr(input logic [12:0] a, input tkr_byte_t d, input logic cs2);
    @(posedge clk);
    addr <= a;
    data_in <= d;
    chip_select_n <= 1'b0;
    second_chip_select_high <= cs2;
    output_enable_n <= 1'b0;
    write_enable_n <= 1'b0;
    @(posedge clk);
    write_enable_n <= 1'b1;
    chip_select_n <= 1'b1;
    second_chip_select_high <= 1'b1;
    data_in <= ~d;
  endtask : odd_wr

  // Held read, counting changes of the lowest data line
  task automatic toggles(input logic [12:0] a, input int k, output int n);
    tkr_byte_t p;
    n = 0;
    rd(a, p);
    repeat (k)
    begin
      @(negedge clk);
      if (data_out[0] !== p[0]) n++;
      p = data_out;
    end
  endtask : toggles
endmodule : tkr_host

// ### dv/tkr_rtc_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %0t ns: read %h expected %h", $time, (g), (e)); end end
module tkr_rtc_bench
  import tkr_pkg::*;
;
  // ----------------------------------------
  // Bench set-up; short second keeps the run small
  // ----------------------------------------
  localparam int SEC = 200;
  typedef struct packed {logic [12:0] a; tkr_byte_t w; logic wr; tkr_byte_t e;} tkr_row_s;
  logic clk, nrst, clk_en, supply_ok, data_oe;
  logic [12:0] addr;
  logic chip_select_n, second_chip_select_high, output_enable_n, write_enable_n;
  tkr_byte_t data_in, data_out, d;
  int miscompares = 0;
  int checks = 0;
  int n;
  tkr_row_s rows [16] = '{
    '{13'h1FF9, 8'h00, 1'b0, 8'h00}, '{13'h1FF8, 8'h00, 1'b0, 8'h00},
    '{13'h1FFA, 8'h00, 1'b0, 8'h00}, '{13'h1FFB, 8'h00, 1'b0, 8'h00},
    '{13'h1FFC, 8'h00, 1'b0, 8'h01}, '{13'h1FFD, 8'h00, 1'b0, 8'h01},
    '{13'h1FFE, 8'h00, 1'b0, 8'h01}, '{13'h1FFF, 8'h00, 1'b0, 8'h00},
    '{13'h0000, 8'h5A, 1'b1, 8'h5A}, '{13'h1FF7, 8'hA5, 1'b1, 8'hA5},
    '{13'h1555, 8'hFF, 1'b1, 8'hFF}, '{13'h0AAA, 8'h00, 1'b1, 8'h00},
    '{13'h1FF8, 8'h3F, 1'b1, 8'h3F}, '{13'h1FF8, 8'h00, 1'b1, 8'h00},
    '{13'h1FFE, 8'hE1, 1'b1, 8'hE1}, '{13'h1FFE, 8'h01, 1'b1, 8'h01}};
  // Bytes from seconds up to year: start time, then two seconds later
  logic [55:0] dates [4][2] = '{
    '{56'h00_02_28_07_23_59_58, 56'h00_02_29_01_00_00_00},
    '{56'h01_02_28_03_23_59_58, 56'h01_03_01_04_00_00_00},
    '{56'h21_04_30_05_23_59_58, 56'h21_05_01_06_00_00_00},
    '{56'h99_12_31_06_23_59_58, 56'h00_01_01_07_00_00_00}};

  tkr_rtc #(.SEC_CYCLES(SEC), .PROBE_HALF(3)) u_tkr_rtc (.clk(clk), .nrst(nrst),
    .clk_en(clk_en), .addr(addr), .chip_select_n(chip_select_n),
    .second_chip_select_high(second_chip_select_high), .output_enable_n(output_enable_n),
    .write_enable_n(write_enable_n), .supply_ok(supply_ok), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe));
  tkr_host u_tkr_host (.clk(clk), .addr(addr), .chip_select_n(chip_select_n),
    .second_chip_select_high(second_chip_select_high), .output_enable_n(output_enable_n),
    .write_enable_n(write_enable_n), .data_in(data_in), .data_out(data_out));

  task automatic set_time(input logic [55:0] t);
    u_tkr_host.wr(13'h1FF8, 8'h80);
    for (int i = 0; i < 7; i++) u_tkr_host.wr(13'h1FF9 + 13'(i), t[8 * i +: 8]);
    u_tkr_host.wr(13'h1FF8, 8'h00);
  endtask : set_time

  task automatic chk_time(input logic [55:0] t);
    tkr_byte_t v;
    u_tkr_host.wr(13'h1FF8, 8'h40);
    for (int i = 0; i < 7; i++)
    begin
      u_tkr_host.rd(13'h1FF9 + 13'(i), v);
      `CHK(v, t[8 * i +: 8])
    end
  endtask : chk_time

  task automatic end_sim;
    if (miscompares == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // Free-running 10 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Hang guard, far past the few thousand cycles needed
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    nrst = 1'b0;
    clk_en = 1'b1;
    supply_ok = 1'b1;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    foreach (rows[i])
    begin
      if (rows[i].wr) u_tkr_host.wr(rows[i].a, rows[i].w);
      u_tkr_host.rd(rows[i].a, d);
      `CHK(d, rows[i].e)
    end
    foreach (dates[i])
    begin
      set_time(dates[i][0]);
      repeat (2 * SEC + 100) @(posedge clk);
      chk_time(dates[i][1]);
    end
    // Counting goes on behind the read hold, one refresh on release
    repeat (2 * SEC) @(posedge clk);
    u_tkr_host.rd(13'h1FF9, d);
    `CHK(d, 8'h00)
    u_tkr_host.wr(13'h1FF8, 8'h00);
    u_tkr_host.rd(13'h1FF9, d);
    `CHK(d, 8'h02)
    set_time(56'h00_01_01_01_00_00_85);
    repeat (2 * SEC) @(posedge clk);
    u_tkr_host.rd(13'h1FF9, d);
    `CHK(d, 8'h85)
    // Square wave on bit 0 only while the flag is set
    u_tkr_host.wr(13'h1FF9, 8'h00);
    u_tkr_host.wr(13'h1FF8, 8'h40);
    u_tkr_host.wr(13'h1FFC, 8'h41);
    u_tkr_host.toggles(13'h1FF9, 18, n);
    `CHK(n, 6)
    u_tkr_host.wr(13'h1FFC, 8'h01);
    u_tkr_host.toggles(13'h1FF9, 18, n);
    `CHK(n, 0)
    // Bad supply: write dropped, bus left floating
    u_tkr_host.wr(13'h0010, 8'h3C);
    supply_ok <= 1'b0;
    u_tkr_host.wr(13'h0010, 8'hC3);
    u_tkr_host.rd(13'h0010, d);
    `CHK(d, 8'h3C)
    `CHK(data_oe, 1'b0)
    @(posedge clk);
    supply_ok <= 1'b1;
    // Write with outputs enabled still lands; second select low blocks it
    u_tkr_host.odd_wr(13'h0011, 8'h66, 1'b1);
    u_tkr_host.odd_wr(13'h0011, 8'h99, 1'b0);
    u_tkr_host.rd(13'h0011, d);
    `CHK(d, 8'h66)
    // Clock enable low freezes state, so this write is never taken
    @(posedge clk);
    clk_en <= 1'b0;
    u_tkr_host.wr(13'h0011, 8'h77);
    clk_en <= 1'b1;
    u_tkr_host.rd(13'h0011, d);
    `CHK(d, 8'h66)
    end_sim();
  end
endmodule : tkr_rtc_bench

// ### dv/tkr_rtc_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------
// Pin checker for the timekeeping RAM
// ----------------------------------------
module tkr_rtc_monitor
  import tkr_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = 20,
  parameter int unsigned PROBE_HALF = 3
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [12:0] addr,
  input wire logic chip_select_n,
  input wire logic second_chip_select_high,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic supply_ok,
  input wire tkr_byte_t data_in,
  input wire tkr_byte_t data_out,
  input wire logic data_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Decoded pin states; a bad supply counts as deselect
  wire sel = supply_ok & !chip_select_n & second_chip_select_high;
  wire rd_c = sel & write_enable_n & !output_enable_n;
  wire wr_c = sel & !write_enable_n;

  property p_oe_read; rd_c |-> data_oe; endproperty
  a_oe_read: assert property (p_oe_read) else $error("read not driven");
  property p_oe_desel; !sel |-> !data_oe; endproperty
  a_oe_desel: assert property (p_oe_desel) else $error("driven while off");
  property p_oe_write; !write_enable_n |-> !data_oe; endproperty
  a_oe_write: assert property (p_oe_write) else $error("driven in write");
  // Read-after-write, address held across the second edge
  property p_ram_back;
    clk_en && wr_c && addr < 13'h1FF8 ##1 clk_en && !wr_c && $stable(addr)
      |=> data_out == $past(data_in, 2);
  endproperty
  a_ram_back: assert property (p_ram_back) else $error("ram byte lost");
  property p_ctrl_back;
    clk_en && wr_c && addr == 13'h1FF8 ##1 clk_en && !wr_c && $stable(addr)
      |=> data_out == $past(data_in, 2);
  endproperty
  a_ctrl_back: assert property (p_ctrl_back) else $error("control lost");
  property p_mon_spare;
    clk_en && wr_c && addr == 13'h1FFE ##1 clk_en && !wr_c && $stable(addr)
      |=> (data_out & 8'hE0) == ($past(data_in, 2) & 8'hE0);
  endproperty
  a_mon_spare: assert property (p_mon_spare) else $error("spare bits lost");
  property p_sec_halt;
    clk_en && wr_c && addr == 13'h1FF9 ##1 clk_en && !wr_c && $stable(addr)
      |=> data_out[7] == $past(data_in[7], 2);
  endproperty
  a_sec_halt: assert property (p_sec_halt) else $error("halt bit lost");
  // A blocked write must not reach the array
  property p_pf_guard;
    clk_en && !supply_ok && $stable(addr) && addr < 13'h1FF8 ##1
      clk_en && !supply_ok && $stable(addr) |=> data_out === $past(data_out);
  endproperty
  a_pf_guard: assert property (p_pf_guard) else $error("write in power fail");
endmodule : tkr_rtc_monitor

bind tkr_rtc tkr_rtc_monitor #(.SEC_CYCLES(SEC_CYCLES), .PROBE_HALF(PROBE_HALF))
  u_tkr_rtc_monitor (.clk(clk), .nrst(nrst), .clk_en(clk_en), .addr(addr),
  .chip_select_n(chip_select_n), .second_chip_select_high(second_chip_select_high),
  .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
  .supply_ok(supply_ok), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));

// ### shared/tkr_pkg.sv
package tkr_pkg;

  // Host bus decode of the pin levels
  typedef enum logic [1:0] {
    TKR_DESELECT,
    TKR_READ,
    TKR_WRITE
  } tkr_mode_e;

  typedef logic [7:0] tkr_byte_t;

endpackage : tkr_pkg

// ### shared/tkr_regs.svh
`ifndef TKR_REGS_SVH
`define TKR_REGS_SVH

// ----------------------------------------------------------------
// Address map of the clock window
// ----------------------------------------------------------------
`define TKR_ADDR_W 13
`define TKR_RAM_DEPTH 8192
`define TKR_CLOCK_CONTROL_OFS 13'h1FF8
`define TKR_SECONDS_COUNT_OFS 13'h1FF9
`define TKR_MINUTES_COUNT_OFS 13'h1FFA
`define TKR_HOURS_COUNT_OFS 13'h1FFB
`define TKR_WEEKDAY_COUNT_OFS 13'h1FFC
`define TKR_MONTH_DAY_COUNT_OFS 13'h1FFD
`define TKR_MONTH_COUNT_OFS 13'h1FFE
`define TKR_YEAR_COUNT_OFS 13'h1FFF

// Register index inside the window (low three address bits)
`define TKR_IDX_CTRL 3'h0
`define TKR_IDX_SEC 3'h1
`define TKR_IDX_MIN 3'h2
`define TKR_IDX_HOUR 3'h3
`define TKR_IDX_WDAY 3'h4
`define TKR_IDX_MDAY 3'h5
`define TKR_IDX_MON 3'h6
`define TKR_IDX_YEAR 3'h7

// ----------------------------------------------------------------
// Field positions and counting field masks
// ----------------------------------------------------------------
`define TKR_CTRL_WHOLD_BIT 7
`define TKR_CTRL_RHOLD_BIT 6
`define TKR_SEC_CRYSTAL_HALT_BIT 7
`define TKR_WDAY_RATE_PROBE_BIT 6
`define TKR_MASK_SEC 8'h7F
`define TKR_MASK_MIN 8'h7F
`define TKR_MASK_HOUR 8'h3F
`define TKR_MASK_WDAY 8'h07
`define TKR_MASK_MDAY 8'h3F
`define TKR_MASK_MON 8'h1F
`define TKR_MASK_YEAR 8'hFF

// ----------------------------------------------------------------
// BCD limits and reset values
// ----------------------------------------------------------------
`define TKR_SEC_LAST 8'h59
`define TKR_MIN_LAST 8'h59
`define TKR_HOUR_LAST 8'h23
`define TKR_WDAY_LAST 8'h07
`define TKR_MON_LAST 8'h12
`define TKR_YEAR_LAST 8'h99
`define TKR_FIRST_ONE 8'h01
`define TKR_ZERO 8'h00
`define TKR_RST_CTRL 8'h00
`define TKR_RST_SEC 8'h00
`define TKR_RST_ONE 8'h01

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TKR_CLK_HZ 10000000
`define TKR_SECOND_S 1
`define TKR_PROBE_HZ 512

`endif

// ### src/tkr_ram.sv
`timescale 1ns/1ps
module tkr_ram
  import tkr_pkg::*;
#(
  parameter int DEPTH = 8192,
  parameter int AW = 13
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [AW-1:0] addr,
  input wire tkr_byte_t wdata,
  output tkr_byte_t rdata
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  tkr_byte_t mem [DEPTH];
  tkr_byte_t rdata_r;
  tkr_byte_t rdata_nxt;

  generate
    if (DEPTH > (1 << AW) || DEPTH < 8)
    begin : g_bad_depth
      $error("tkr_ram: depth does not fit the address width");
    end
  endgenerate

  // Read word follows the address one cycle later
  always_comb
  begin
    rdata_nxt = mem[addr];
  end

  // Array has no reset: contents are kept like battery backed cells
  always_ff @(posedge clk)
  begin
    if (clk_en && wr_en)
    begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_r <= 8'h00;
    end
    else if (clk_en)
    begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;

endmodule : tkr_ram

// ### src/tkr_rtc.sv
`timescale 1ns/1ps
`include "tkr_regs.svh"
// Operation
// R1: 8K bytes, top eight are clock registers
// R2: BCD 24-hour time, leap years to 2100
// R3: Month length rollover handled automatically
// R4: Counters separate from host-visible registers
// R5: Host sets read hold before reading
// R6: Read hold stops counter-to-register transfer
// R7: Held registers show time at hold
// R8: Counters keep advancing during read hold
// R9: Release refreshes all registers within second
// R10: Write hold halts updates for loading
// R11: Clearing write hold loads the counters
// R12: Seconds MSB stops the oscillator
// R13: Test flag toggles seconds LSB 512 Hz
// R14: Lowest data line toggles during seconds read
// R15: Unused clock bits are plain RAM
// R16: Calibration writes accepted, rate unchanged
// R17: Bad supply deselects the device
// R18: Read when write high, selected, enabled
// R19: Write when strobe and select active
// R20: State kept through battery backup
// R21: Data lines released unless driving read
// R22: Control bits treated as nonvolatile state
module tkr_rtc
  import tkr_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `TKR_CLK_HZ * `TKR_SECOND_S,
  parameter int unsigned PROBE_HALF = `TKR_CLK_HZ / (2 * `TKR_PROBE_HZ)
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [12:0] addr,
  input wire logic chip_select_n,
  input wire logic second_chip_select_high,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic supply_ok,
  input wire tkr_byte_t data_in,
  output tkr_byte_t data_out,
  output logic data_oe
);

  // ----------------------------------------------------------------
  // Parameter checks and widths
  // ----------------------------------------------------------------
  localparam int TW = $clog2(SEC_CYCLES + 1);
  localparam int PW = $clog2(PROBE_HALF + 1);

  generate
    if (SEC_CYCLES < 2 || PROBE_HALF < 1 || PROBE_HALF >= SEC_CYCLES)
    begin : g_bad_timing
      $error("tkr_rtc: second or probe period cannot be served");
    end
  endgenerate

  // ----------------------------------------------------------------
  // BCD helpers
  // ----------------------------------------------------------------
  function automatic tkr_byte_t bcd_inc(input tkr_byte_t v);
    tkr_byte_t r;
    if (v[3:0] == 4'h9)
    begin
      r = {4'(v[7:4] + 4'h1), 4'h0};
    end
    else
    begin
      r = {v[7:4], 4'(v[3:0] + 4'h1)};
    end
    return r;
  endfunction : bcd_inc

  // Divisible by four in BCD: even tens with 0/4/8, odd tens with 2/6
  function automatic logic is_leap(input tkr_byte_t yr);
    logic r;
    if (!yr[4])
    begin
      r = (yr[3:0] == 4'h0) || (yr[3:0] == 4'h4) || (yr[3:0] == 4'h8);
    end
    else
    begin
      r = (yr[3:0] == 4'h2) || (yr[3:0] == 4'h6);
    end
    return r;
  endfunction : is_leap

  function automatic tkr_byte_t last_day(input tkr_byte_t mon, input logic leap);
    tkr_byte_t r;
    case (mon)
      8'h02: r = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
      default: r = 8'h31;
    endcase
    return r;
  endfunction : last_day

  // Bits of each clock location that belong to the running count
  function automatic tkr_byte_t field_mask(input logic [2:0] idx);
    tkr_byte_t r;
    case (idx)
      `TKR_IDX_SEC: r = `TKR_MASK_SEC;
      `TKR_IDX_MIN: r = `TKR_MASK_MIN;
      `TKR_IDX_HOUR: r = `TKR_MASK_HOUR;
      `TKR_IDX_WDAY: r = `TKR_MASK_WDAY;
      `TKR_IDX_MDAY: r = `TKR_MASK_MDAY;
      `TKR_IDX_MON: r = `TKR_MASK_MON;
      `TKR_IDX_YEAR: r = `TKR_MASK_YEAR;
      default: r = 8'h00;
    endcase
    return r;
  endfunction : field_mask

  // ----------------------------------------------------------------
  // Host bus decode
  // ----------------------------------------------------------------
  tkr_mode_e mode;
  logic in_clock;
  logic [2:0] idx;

  assign in_clock = (addr >= `TKR_CLOCK_CONTROL_OFS);
  assign idx = addr[2:0];

  // R17: power fail masks both selects
  // R18: read mode with strobe high
  // R19: write mode while both strobe and select active
  always_comb
  begin
    if (!(supply_ok && !chip_select_n && second_chip_select_high))
    begin
      mode = TKR_DESELECT;
    end
    else if (!write_enable_n)
    begin
      mode = TKR_WRITE;
    end
    else
    begin
      mode = TKR_READ;
    end
  end

  // R21: drive only a read with outputs enabled
  assign data_oe = (mode == TKR_READ) && !output_enable_n;

  // ----------------------------------------------------------------
  // Timekeeping state
  // ----------------------------------------------------------------
  // vis_r are the host-visible locations, cnt_r the running counters
  tkr_byte_t vis_r [8];
  tkr_byte_t vis_nxt [8];
  tkr_byte_t cnt_r [8];
  tkr_byte_t cnt_nxt [8];
  logic [TW-1:0] tick_r;
  logic [TW-1:0] tick_nxt;
  logic [PW-1:0] pcnt_r;
  logic [PW-1:0] pcnt_nxt;
  logic probe_r;
  logic probe_nxt;
  logic running;
  logic probing;
  logic held;

  // R12: halt bit stops the time base
  assign running = !vis_r[`TKR_IDX_SEC][`TKR_SEC_CRYSTAL_HALT_BIT];
  assign probing = running && vis_r[`TKR_IDX_WDAY][`TKR_WDAY_RATE_PROBE_BIT];
  // R6: either hold bit freezes the visible copy
  // R10: write hold likewise
  assign held = vis_r[`TKR_IDX_CTRL][`TKR_CTRL_WHOLD_BIT]
    || vis_r[`TKR_IDX_CTRL][`TKR_CTRL_RHOLD_BIT];

  // Next-state of counters, visible copy and 512 Hz probe
  always_comb
  begin
    logic c;
    c = 1'b0;
    vis_nxt = vis_r;
    cnt_nxt = cnt_r;
    tick_nxt = tick_r;
    pcnt_nxt = pcnt_r;
    probe_nxt = probe_r;
    // R16: rate is fixed by the cycle count alone
    if (running)
    begin
      if (tick_r == TW'(SEC_CYCLES - 1))
      begin
        tick_nxt = '0;
        c = 1'b1;
      end
      else
      begin
        tick_nxt = tick_r + TW'(1);
      end
    end
    // R8: counters advance regardless of holds
    // R2: BCD carry chain through a 24-hour day
    if (c)
    begin
      c = (cnt_r[`TKR_IDX_SEC] == `TKR_SEC_LAST);
      cnt_nxt[`TKR_IDX_SEC] = c ? `TKR_ZERO : bcd_inc(cnt_r[`TKR_IDX_SEC]);
      if (c)
      begin
        c = (cnt_r[`TKR_IDX_MIN] == `TKR_MIN_LAST);
        cnt_nxt[`TKR_IDX_MIN] = c ? `TKR_ZERO : bcd_inc(cnt_r[`TKR_IDX_MIN]);
      end
      if (c)
      begin
        c = (cnt_r[`TKR_IDX_HOUR] == `TKR_HOUR_LAST);
        cnt_nxt[`TKR_IDX_HOUR] = c ? `TKR_ZERO : bcd_inc(cnt_r[`TKR_IDX_HOUR]);
        cnt_nxt[`TKR_IDX_WDAY] = (cnt_r[`TKR_IDX_WDAY] == `TKR_WDAY_LAST)
          ? `TKR_FIRST_ONE : bcd_inc(cnt_r[`TKR_IDX_WDAY]);
      end
      // R3: date wraps at this month's length
      if (c)
      begin
        c = (cnt_r[`TKR_IDX_MDAY] ==
          last_day(cnt_r[`TKR_IDX_MON], is_leap(cnt_r[`TKR_IDX_YEAR])));
        cnt_nxt[`TKR_IDX_MDAY] = c ? `TKR_FIRST_ONE : bcd_inc(cnt_r[`TKR_IDX_MDAY]);
      end
      if (c)
      begin
        c = (cnt_r[`TKR_IDX_MON] == `TKR_MON_LAST);
        cnt_nxt[`TKR_IDX_MON] = c ? `TKR_FIRST_ONE : bcd_inc(cnt_r[`TKR_IDX_MON]);
      end
      if (c)
      begin
        cnt_nxt[`TKR_IDX_YEAR] = (cnt_r[`TKR_IDX_YEAR] == `TKR_YEAR_LAST)
          ? `TKR_ZERO : bcd_inc(cnt_r[`TKR_IDX_YEAR]);
      end
    end
    // R13: probe square wave while test flag set and running
    if (probing)
    begin
      if (pcnt_r == PW'(PROBE_HALF - 1))
      begin
        pcnt_nxt = '0;
        probe_nxt = !probe_r;
      end
      else
      begin
        pcnt_nxt = pcnt_r + PW'(1);
      end
    end
    // R4: visible copy fed from counters and host writes; counters load from it only at end of write hold
    // R7: no copy while held keeps the captured time
    // R9: copy every cycle once released, all fields together
    if (!held)
    begin
      for (int i = 1; i < 8; i++)
      begin
        vis_nxt[i] = (vis_r[i] & ~field_mask(3'(i))) | (cnt_nxt[i] & field_mask(3'(i)));
      end
    end
    // R1: clock locations written like RAM
    // R15: unused bits stored as written
    // R16: calibration bits of control simply stored
    if (mode == TKR_WRITE && in_clock)
    begin
      vis_nxt[idx] = data_in;
      // R11: end of write hold loads counters from the visible copy
      if (idx == `TKR_IDX_CTRL && !data_in[`TKR_CTRL_WHOLD_BIT]
        && vis_r[`TKR_IDX_CTRL][`TKR_CTRL_WHOLD_BIT])
      begin
        for (int i = 1; i < 8; i++)
        begin
          cnt_nxt[i] = vis_r[i] & field_mask(3'(i));
        end
        tick_nxt = '0;
      end
    end
  end

  // R20: clk_en low freezes everything, as on battery power
  // R22: reset is first power-up only, supply loss keeps state
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      vis_r[0] <= `TKR_RST_CTRL;
      cnt_r[0] <= `TKR_RST_CTRL;
      for (int i = 1; i < 8; i++)
      begin
        vis_r[i] <= (i >= 4 && i <= 6) ? `TKR_RST_ONE : `TKR_RST_SEC;
        cnt_r[i] <= (i >= 4 && i <= 6) ? `TKR_RST_ONE : `TKR_RST_SEC;
      end
      tick_r <= '0;
      pcnt_r <= '0;
      probe_r <= 1'b0;
    end
    else if (clk_en)
    begin
      vis_r <= vis_nxt;
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
      pcnt_r <= pcnt_nxt;
      probe_r <= probe_nxt;
    end
  end

  // ----------------------------------------------------------------
  // RAM array and read path
  // ----------------------------------------------------------------
  tkr_byte_t ram_rdata;
  tkr_byte_t rd_clk_r;
  tkr_byte_t rd_clk_nxt;
  logic rd_sel_r;
  logic rd_sel_nxt;

  // Clock locations never reach the array, so it sees only plain bytes
  tkr_ram #(
    .DEPTH(`TKR_RAM_DEPTH),
    .AW(`TKR_ADDR_W)
  ) u_ram (
    .clk(clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .wr_en((mode == TKR_WRITE) && !in_clock),
    .addr(addr),
    .wdata(data_in),
    .rdata(ram_rdata)
  );

  // R14: seconds read shows the probe on the lowest data line
  always_comb
  begin
    rd_sel_nxt = in_clock;
    rd_clk_nxt = vis_r[idx];
    if (idx == `TKR_IDX_SEC && probing)
    begin
      rd_clk_nxt[0] = probe_r;
    end
  end

  // Both read sources registered, so data is one cycle behind address
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_clk_r <= 8'h00;
      rd_sel_r <= 1'b0;
    end
    else if (clk_en)
    begin
      rd_clk_r <= rd_clk_nxt;
      rd_sel_r <= rd_sel_nxt;
    end
  end

  assign data_out = rd_sel_r ? rd_clk_r : ram_rdata;

endmodule : tkr_rtc
